// *** pkcx_axil.sv ***
// axi4-lite slave in front of the controller registers
`timescale 1ns/10ps
`include "pkcx_consts.svh"
module pkcx_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pkcx_pkg::pkcx_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire pkcx_pkg::pkcx_word_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire pkcx_pkg::pkcx_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output pkcx_pkg::pkcx_word_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    pkcx_reg_if.bus rg
);
    import pkcx_pkg::*;
    typedef struct packed {
        logic aw_h;
        logic w_h;
        pkcx_addr_t awa;
        pkcx_word_t wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        pkcx_word_t rd;
        logic [1:0] rr;
    } pkcx_axil_t;
    pkcx_axil_t r_reg, r_next;

    assign s_axi_awready = !r_reg.aw_h && !r_reg.bv;
    assign s_axi_wready = !r_reg.w_h && !r_reg.bv;
    assign s_axi_arready = !r_reg.rv;
    assign rg.wr = r_reg.aw_h && r_reg.w_h;
    assign rg.waddr = r_reg.awa;
    assign rg.wdata = r_reg.wd;
    assign rg.wstrb = r_reg.ws;
    assign rg.raddr = s_axi_araddr;

    always_comb begin
        r_next = r_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            r_next.aw_h = 1'b1;
            r_next.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_next.w_h = 1'b1;
            r_next.wd = s_axi_wdata;
            r_next.ws = s_axi_wstrb;
        end
        if (rg.wr) begin
            r_next.aw_h = 1'b0;
            r_next.w_h = 1'b0;
            r_next.bv = 1'b1;
            r_next.br = rg.wr_ok ? `PKCX_RESP_OK : `PKCX_RESP_ERR;
        end
        if (r_reg.bv && s_axi_bready) begin
            r_next.bv = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            r_next.rv = 1'b1;
            r_next.rd = rg.rdata;
            r_next.rr = rg.rd_ok ? `PKCX_RESP_OK : `PKCX_RESP_ERR;
        end
        if (r_reg.rv && s_axi_rready) begin
            r_next.rv = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign s_axi_bvalid = r_reg.bv;
    assign s_axi_bresp = r_reg.br;
    assign s_axi_rvalid = r_reg.rv;
    assign s_axi_rdata = r_reg.rd;
    assign s_axi_rresp = r_reg.rr;
endmodule : pkcx_axil

// *** pkcx_consts.svh ***
// offsets, field positions and counts of the public key unit controller
`ifndef PKCX_CONSTS_SVH
`define PKCX_CONSTS_SVH
`define PKCX_CTRL_OFS 8'h00
`define PKCX_STAT_OFS 8'h04
`define PKCX_EXPB_OFS 8'h40
`define PKCX_EXPB_END 8'h5c
`define PKCX_C_START 0
`define PKCX_C_EXP 1
`define PKCX_C_IRQ 2
`define PKCX_C_AP 5:4
`define PKCX_C_BP 7:6
`define PKCX_C_MOD 15:8
`define PKCX_C_ESZ 23:16
`define PKCX_S_BUSY 0
`define PKCX_S_DONE 1
`define PKCX_S_ERR 2
`define PKCX_S_SENT 11:8
`define PKCX_U_CTRL 8'h00
`define PKCX_U_STAT 8'h04
`define PKCX_U_EXPW 8'h08
`define PKCX_U_MOD 8'h0c
`define PKCX_U_ESZ 8'h10
`define PKCX_UC_GO 0
`define PKCX_UC_ENT 11:4
`define PKCX_UC_AP 13:12
`define PKCX_UC_BP 15:14
`define PKCX_US_DONE 0
`define PKCX_US_ERDY 1
`define PKCX_ENT_MUL2 8'h0b
`define PKCX_ENT_EXP 8'h07
`define PKCX_MOD_MIN 8'h04
`define PKCX_EXP_WORDS 8
`define PKCX_CLK_NS 5
`define PKCX_POLL_NS 320
`define PKCX_POLL_CYC 8'((`PKCX_POLL_NS) / (`PKCX_CLK_NS))
`define PKCX_RESP_OK 2'b00
`define PKCX_RESP_ERR 2'b10
`endif

// *** pkcx_devport.sv ***
// one register access at a time towards the public key unit pins
`timescale 1ns/10ps
module pkcx_devport (
    input wire logic aclk,
    input wire logic aresetn,
    output logic unit_cs,
    output logic unit_we,
    output pkcx_pkg::pkcx_addr_t unit_addr,
    output pkcx_pkg::pkcx_word_t unit_wdata,
    input wire pkcx_pkg::pkcx_word_t unit_rdata,
    input wire logic unit_ack,
    pkcx_dev_if.port d
);
    import pkcx_pkg::*;
    typedef struct packed {
        logic cs;
        logic we;
        pkcx_addr_t addr;
        pkcx_word_t wdata;
        logic done;
        pkcx_word_t rdata;
    } pkcx_devport_t;
    pkcx_devport_t r_reg, r_next;

    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        // the done cycle still shows the old request, so it must not restart
        if (!r_reg.cs && d.req && !r_reg.done) begin
            r_next.cs = 1'b1;
            r_next.we = d.we;
            r_next.addr = d.addr;
            r_next.wdata = d.wdata;
        end else if (r_reg.cs && unit_ack) begin
            r_next.cs = 1'b0;
            r_next.done = 1'b1;
            r_next.rdata = unit_rdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign unit_cs = r_reg.cs;
    assign unit_we = r_reg.we;
    assign unit_addr = r_reg.addr;
    assign unit_wdata = r_reg.wdata;
    assign d.done = r_reg.done;
    assign d.rdata = r_reg.rdata;
endmodule : pkcx_devport

// *** pkcx_if.sv ***
// register-side and unit-side carriers between the controller modules
`timescale 1ns/10ps
interface pkcx_reg_if;
    import pkcx_pkg::*;
    logic wr;
    pkcx_addr_t waddr;
    pkcx_word_t wdata;
    logic [3:0] wstrb;
    logic wr_ok;
    pkcx_addr_t raddr;
    pkcx_word_t rdata;
    logic rd_ok;
    modport bus (output wr, waddr, wdata, wstrb, raddr, input wr_ok, rdata, rd_ok);
    modport regs (input wr, waddr, wdata, wstrb, raddr, output wr_ok, rdata, rd_ok);
endinterface : pkcx_reg_if

interface pkcx_dev_if;
    import pkcx_pkg::*;
    logic req;
    logic we;
    pkcx_addr_t addr;
    pkcx_word_t wdata;
    logic done;
    pkcx_word_t rdata;
    modport ctl (output req, we, addr, wdata, input done, rdata);
    modport port (input req, we, addr, wdata, output done, rdata);
endinterface : pkcx_dev_if

// *** pkcx_pkg.sv ***
// types shared by the public key unit controller
package pkcx_pkg;
    typedef logic [31:0] pkcx_word_t;
    typedef logic [7:0] pkcx_addr_t;
    typedef enum logic [3:0] {
        S_IDLE, S_MOD, S_ESZ, S_CTL, S_GO, S_WAIT, S_STAT, S_EXPW
    } pkcx_state_t;

    function automatic pkcx_word_t pkcx_merge(input pkcx_word_t old, input pkcx_word_t nw, input logic [3:0] s);
        pkcx_word_t m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                m[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return m;
    endfunction : pkcx_merge
endpackage : pkcx_pkg

// *** pkcx_tb.sv ***
// self-checking bench for the public key unit controller
`timescale 1ns/10ps
module tb;
    import pkcx_pkg::*;
    logic aclk, aresetn, slow;
    pkcx_addr_t s_axi_awaddr, s_axi_araddr, unit_addr;
    pkcx_word_t s_axi_wdata, s_axi_rdata, unit_rdata, unit_wdata, v;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic unit_cs, unit_we, unit_ack, host_ready_out_n, unit_irq;
    int err_count, checks, cyc;
    pkcx_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .unit_cs, .unit_we, .unit_addr,
        .unit_wdata, .unit_rdata, .unit_ack, .host_ready_out_n, .unit_irq);
    pkcx_unit_model dev (.aclk, .aresetn, .slow, .unit_cs, .unit_we, .unit_addr, .unit_wdata, .unit_rdata,
        .unit_ack, .host_ready_out_n, .unit_irq);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    task automatic axw(input pkcx_addr_t a, input pkcx_word_t d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input pkcx_addr_t a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr
    // polls status until the controller is no longer busy
    task automatic wait_end();
        do axr(8'h04); while (v[0] !== 1'b0);
    endtask : wait_end
    function automatic pkcx_word_t ctl(input logic op, input logic im, input logic [1:0] ap, input logic [1:0] bp,
        input logic [7:0] md, input logic [7:0] es);
        return {8'h00, es, md, bp, ap, 1'b0, im, op, 1'b1};
    endfunction : ctl
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        err_count = 0;
        checks = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axr(8'h00);
        check(v, 32'h0);
        axr(8'h04);
        check(v, 32'h0);
        axr(8'h30);
        check({v[31:2], resp}, 32'h2);
        axw(8'h30, 32'h1);
        check({30'h0, resp}, 32'h2);
        s_axi_wstrb <= 4'h2;
        axw(8'h44, 32'hffff_ffff);
        s_axi_wstrb <= 4'hf;
        axr(8'h44);
        check(v, 32'h0000_ff00);
        $display("test registers done");
        axw(8'h00, ctl(1'b0, 1'b0, 2'd2, 2'd1, 8'h04, 8'h00));
        wait_end();
        check(v, 32'h2);
        check({24'h0, dev.ent}, 32'h0b);
        check({24'h0, dev.md}, 32'h04);
        check({28'h0, dev.bp, dev.ap}, 32'h6);
        axr(8'h00);
        check(v, 32'h460);
        $display("test multiply done");
        axw(8'h00, ctl(1'b0, 1'b0, 2'd0, 2'd0, 8'h03, 8'h00));
        wait_end();
        check(v & 32'h5, 32'h4);
        $display("test short modulus done");
        slow <= 1'b1;
        axw(8'h40, 32'h8000_0001);
        axw(8'h44, 32'h1234_5678);
        axw(8'h48, 32'h0000_00ff);
        axw(8'h00, ctl(1'b1, 1'b0, 2'd3, 2'd3, 8'h05, 8'h0b));
        wait_end();
        check(v, 32'h0000_0302);
        check({24'h0, dev.ent}, 32'h07);
        check({28'h0, dev.bp, dev.ap}, 32'h0);
        check(dev.words[0], 32'h8000_0001);
        check(dev.words[1], 32'h1234_5678);
        check(dev.words[2], 32'h0000_00ff);
        $display("test exponentiation done");
        slow <= 1'b0;
        axw(8'h40, 32'h0000_0005);
        axw(8'h00, ctl(1'b1, 1'b1, 2'd0, 2'd0, 8'h04, 8'h00));
        wait_end();
        check(v, 32'h0000_0102);
        check(dev.words[0], 32'h5);
        check(dev.got, 32'h1);
        $display("test one byte exponent done");
        axw(8'h40, 32'h1);
        axw(8'h00, ctl(1'b1, 1'b0, 2'd0, 2'd0, 8'h04, 8'h00));
        wait_end();
        check(v & 32'h5, 32'h4);
        $display("test exponent of one done");
        axw(8'h00, ctl(1'b1, 1'b0, 2'd0, 2'd0, 8'h04, 8'h20));
        wait_end();
        check(v & 32'h5, 32'h4);
        $display("test oversized exponent done");
        final_report();
    end
endmodule : tb

// *** pkcx_top.sv ***
// host controller that runs double-reduction multiply and exponentiation on the public key unit
`timescale 1ns/10ps
`include "pkcx_consts.svh"
module pkcx_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pkcx_pkg::pkcx_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire pkcx_pkg::pkcx_word_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire pkcx_pkg::pkcx_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output pkcx_pkg::pkcx_word_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic unit_cs,
    output logic unit_we,
    output pkcx_pkg::pkcx_addr_t unit_addr,
    output pkcx_pkg::pkcx_word_t unit_wdata,
    input wire pkcx_pkg::pkcx_word_t unit_rdata,
    input wire logic unit_ack,
    input wire logic host_ready_out_n,
    input wire logic unit_irq
);
    import pkcx_pkg::*;
    typedef struct packed {
        pkcx_state_t st;
        pkcx_word_t ctrl;
        logic busy;
        logic done;
        logic err;
        logic [3:0] sent;
        logic [3:0] nwords;
        logic [7:0] poll;
        logic [`PKCX_EXP_WORDS-1:0][31:0] expb;
    } pkcx_main_t;
    pkcx_main_t r_reg, r_next;

    pkcx_reg_if rg ();
    pkcx_dev_if dif ();

    pkcx_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rg(rg.bus)
    );

    pkcx_devport u_devport (
        .aclk(aclk),
        .aresetn(aresetn),
        .unit_cs(unit_cs),
        .unit_we(unit_we),
        .unit_addr(unit_addr),
        .unit_wdata(unit_wdata),
        .unit_rdata(unit_rdata),
        .unit_ack(unit_ack),
        .d(dif.port)
    );

    // decode of the software-side registers
    pkcx_word_t wctl;
    logic [3:0] words_new;
    logic w_ctrl, w_expb, r_expb, is_exp, ev;
    logic [`PKCX_EXP_WORDS-1:0] wnz;
    pkcx_word_t ucw, stat;

    assign wctl = pkcx_merge(r_reg.ctrl, rg.wdata, rg.wstrb);
    assign words_new = 4'(wctl[`PKCX_C_ESZ] >> 2) + 4'h1;
    assign w_ctrl = rg.waddr == `PKCX_CTRL_OFS;
    assign w_expb = rg.waddr >= `PKCX_EXPB_OFS && rg.waddr <= `PKCX_EXPB_END && rg.waddr[1:0] == 2'b00;
    assign r_expb = rg.raddr >= `PKCX_EXPB_OFS && rg.raddr <= `PKCX_EXPB_END && rg.raddr[1:0] == 2'b00;
    assign is_exp = r_reg.ctrl[`PKCX_C_EXP];
    assign ev = !host_ready_out_n || unit_irq;

    // exponent value above one: any higher word nonzero, or the last word above one
    for (genvar i = 0; i < `PKCX_EXP_WORDS; i++) begin : g_nz
        assign wnz[i] = (4'(i) + 4'h1 < words_new) ? |r_reg.expb[i] :
                        (4'(i) + 4'h1 == words_new) ? |r_reg.expb[i][31:1] : 1'b0;
    end

    always_comb begin
        ucw = '0;
        if (is_exp) begin
            // base must already sit in A in Montgomery form, pointers left at zero
            ucw[`PKCX_UC_ENT] = `PKCX_ENT_EXP;
        end else begin
            ucw[`PKCX_UC_ENT] = `PKCX_ENT_MUL2;
            ucw[`PKCX_UC_AP] = r_reg.ctrl[`PKCX_C_AP];
            ucw[`PKCX_UC_BP] = r_reg.ctrl[`PKCX_C_BP];
        end
        ucw[`PKCX_UC_GO] = r_reg.st == S_GO;
        stat = '0;
        stat[`PKCX_S_BUSY] = r_reg.busy;
        stat[`PKCX_S_DONE] = r_reg.done;
        stat[`PKCX_S_ERR] = r_reg.err;
        stat[`PKCX_S_SENT] = r_reg.sent;
    end

    // unit accesses follow the registered state, so they stay stable until done
    always_comb begin
        dif.req = 1'b1;
        dif.we = 1'b1;
        dif.addr = `PKCX_U_CTRL;
        dif.wdata = ucw;
        unique case (r_reg.st)
            S_MOD: begin
                dif.addr = `PKCX_U_MOD;
                dif.wdata = {24'h0, r_reg.ctrl[`PKCX_C_MOD]};
            end
            S_ESZ: begin
                dif.addr = `PKCX_U_ESZ;
                dif.wdata = {24'h0, r_reg.ctrl[`PKCX_C_ESZ]};
            end
            S_CTL, S_GO: begin
                dif.addr = `PKCX_U_CTRL;
            end
            S_STAT: begin
                dif.we = 1'b0;
                dif.addr = `PKCX_U_STAT;
            end
            S_EXPW: begin
                dif.addr = `PKCX_U_EXPW;
                dif.wdata = r_reg.expb[r_reg.sent[2:0]];
            end
            S_IDLE, S_WAIT: begin
                dif.req = 1'b0;
            end
        endcase
    end

    always_comb begin
        rg.wr_ok = w_ctrl || w_expb;
        rg.rd_ok = 1'b1;
        if (rg.raddr == `PKCX_CTRL_OFS) begin
            rg.rdata = r_reg.ctrl;
        end else if (rg.raddr == `PKCX_STAT_OFS) begin
            rg.rdata = stat;
        end else if (r_expb) begin
            rg.rdata = r_reg.expb[rg.raddr[4:2]];
        end else begin
            rg.rdata = '0;
            rg.rd_ok = 1'b0;
        end
    end

    always_comb begin
        r_next = r_reg;
        // configuration is frozen while a routine runs
        if (rg.wr && !r_reg.busy && w_expb) begin
            r_next.expb[rg.waddr[4:2]] = pkcx_merge(r_reg.expb[rg.waddr[4:2]], rg.wdata, rg.wstrb);
        end
        if (rg.wr && !r_reg.busy && w_ctrl) begin
            r_next.ctrl = wctl;
            r_next.ctrl[`PKCX_C_START] = 1'b0;
            if (wctl[`PKCX_C_START]) begin
                r_next.done = 1'b0;
                r_next.sent = 4'h0;
                r_next.nwords = words_new;
                if (wctl[`PKCX_C_MOD] < `PKCX_MOD_MIN || (wctl[`PKCX_C_EXP] &&
                    (wctl[`PKCX_C_ESZ] >= 8'(`PKCX_EXP_WORDS * 4) || !(|wnz)))) begin
                    r_next.err = 1'b1;
                end else begin
                    r_next.err = 1'b0;
                    r_next.busy = 1'b1;
                    r_next.st = S_MOD;
                end
            end
        end
        unique case (r_reg.st)
            S_IDLE: begin
            end
            S_MOD: if (dif.done) begin
                r_next.st = is_exp ? S_ESZ : S_CTL;
            end
            S_ESZ, S_CTL: if (dif.done) begin
                r_next.st = r_reg.st == S_ESZ ? S_CTL : S_GO;
            end
            S_GO, S_EXPW: if (dif.done) begin
                // the unit runs its own multiplies; we only wait and feed words
                r_next.st = S_WAIT;
                r_next.poll = `PKCX_POLL_CYC;
                if (r_reg.st == S_EXPW) begin
                    r_next.sent = r_reg.sent + 4'h1;
                end
            end
            S_WAIT: begin
                // masked request: poll at once; otherwise wait for the pins or a slow poll
                if (!r_reg.ctrl[`PKCX_C_IRQ] || ev || r_reg.poll == 8'h0) begin
                    r_next.st = S_STAT;
                end else begin
                    r_next.poll = r_reg.poll - 8'h1;
                end
            end
            S_STAT: if (dif.done) begin
                r_next.poll = `PKCX_POLL_CYC;
                if (dif.rdata[`PKCX_US_DONE]) begin
                    r_next.st = S_IDLE;
                    r_next.busy = 1'b0;
                    r_next.done = 1'b1;
                end else if (dif.rdata[`PKCX_US_ERDY] && is_exp) begin
                    // the flag is re-read after each word, the unit clears it on the write
                    if (r_reg.sent < r_reg.nwords) begin
                        r_next.st = S_EXPW;
                    end else begin
                        r_next.st = S_IDLE;
                        r_next.busy = 1'b0;
                        r_next.err = 1'b1;
                    end
                end else begin
                    r_next.st = S_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_mod_at_launch: assert property ((r_reg.st == S_GO) |-> r_reg.ctrl[`PKCX_C_MOD] >= `PKCX_MOD_MIN)
        else $error("launch with modulus below minimum");
    a_mul2_pointers: assert property ((unit_cs && unit_addr == `PKCX_U_CTRL && !is_exp) |->
        unit_wdata[`PKCX_UC_AP] == r_reg.ctrl[`PKCX_C_AP] && unit_wdata[`PKCX_UC_BP] == r_reg.ctrl[`PKCX_C_BP])
        else $error("multiply launched with wrong pointers");
    a_exp_pointers_zero: assert property ((unit_cs && unit_addr == `PKCX_U_CTRL && is_exp) |->
        unit_wdata[`PKCX_UC_AP] == 2'b00 && unit_wdata[`PKCX_UC_BP] == 2'b00)
        else $error("exponentiation launched with nonzero pointers");
    a_word_order: assert property ((r_reg.st == S_EXPW && dif.done) |=> r_reg.sent == $past(r_reg.sent) + 4'h1)
        else $error("exponent word index did not advance");
    a_word_data: assert property ((unit_cs && unit_addr == `PKCX_U_EXPW) |->
        unit_wdata == r_reg.expb[r_reg.sent[2:0]])
        else $error("exponent word data mismatch");
    a_word_after_flag: assert property ($rose(r_reg.st == S_EXPW) |->
        $past(r_reg.st) == S_STAT && $past(dif.rdata[`PKCX_US_ERDY]))
        else $error("exponent word written without request");
    a_poll_after_go: assert property ($rose(r_reg.st == S_WAIT) |->
        $past(r_reg.st) inside {S_GO, S_STAT, S_EXPW})
        else $error("status watched before launch");
    a_irq_wait: assert property ((r_reg.st == S_WAIT && r_reg.ctrl[`PKCX_C_IRQ] && !ev && r_reg.poll != 8'h0)
        |=> r_reg.st == S_WAIT ##1 (r_reg.st == S_WAIT || r_reg.st == S_STAT))
        else $error("left wait without event or poll expiry");
    a_poll_now: assert property ((r_reg.st == S_WAIT && !r_reg.ctrl[`PKCX_C_IRQ]) |=> r_reg.st == S_STAT)
        else $error("polling mode did not read status");
    a_size_written: assert property ((r_reg.st == S_ESZ) |-> dif.wdata[7:0] == r_reg.ctrl[`PKCX_C_ESZ])
        else $error("exponent size field not passed through");
    a_exp_gt_one: assert property ((rg.wr && w_ctrl && !r_reg.busy && wctl[`PKCX_C_START]
        && wctl[`PKCX_C_EXP] && !(|wnz)) |=> r_reg.err && !r_reg.busy)
        else $error("exponent of one or zero was launched");

    c_mul2_done: cover property (r_reg.busy && !is_exp ##1 r_reg.done);
    c_exp_done: cover property (r_reg.busy && is_exp && r_reg.sent > 4'h1 ##1 r_reg.done);
    c_word_sent: cover property (r_reg.st == S_EXPW && dif.done);
    c_refused: cover property ($rose(r_reg.err));
endmodule : pkcx_top

// *** pkcx_unit_model.sv ***
// behavioural model of the public key unit behind its register pins
`timescale 1ns/10ps
module pkcx_unit_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic unit_cs,
    input wire logic unit_we,
    input wire pkcx_pkg::pkcx_addr_t unit_addr,
    input wire pkcx_pkg::pkcx_word_t unit_wdata,
    output pkcx_pkg::pkcx_word_t unit_rdata,
    output logic unit_ack,
    output logic host_ready_out_n,
    output logic unit_irq
);
    import pkcx_pkg::*;
    logic [7:0] ent, esz, md;
    logic [1:0] ap, bp;
    logic erdy, done;
    int got, need, run, dly;
    pkcx_word_t words [8];
    assign host_ready_out_n = !erdy;
    assign unit_irq = erdy;
    always @(posedge aclk) begin
        if (!aresetn) begin
            unit_ack <= 1'b0;
            unit_rdata <= 32'h0;
            erdy <= 1'b0;
            done <= 1'b0;
            run <= 0;
            dly <= 0;
        end else begin
            unit_ack <= 1'b0;
            // idle read data keeps moving so a stale sample never looks valid
            if (!unit_ack) unit_rdata <= ~unit_rdata;
            if (unit_cs && !unit_ack) begin
                if (dly < (slow ? 3 : 0)) dly <= dly + 1;
                else begin
                    dly <= 0;
                    unit_ack <= 1'b1;
                    unit_rdata <= {30'h0, erdy, done};
                end
            end
            if (run > 0) begin
                run <= run - 1;
                if (run == 1 && got < need) erdy <= 1'b1;
                else if (run == 1) done <= 1'b1;
            end
            if (unit_cs && unit_ack && unit_we) begin
                case (unit_addr)
                    8'h0c: md <= unit_wdata[7:0];
                    8'h10: esz <= unit_wdata[7:0];
                    8'h00: begin
                        ent <= unit_wdata[11:4];
                        ap <= unit_wdata[13:12];
                        bp <= unit_wdata[15:14];
                        if (unit_wdata[0]) begin
                            got <= 0;
                            need <= (unit_wdata[11:4] == 8'h07) ? int'(esz[4:2]) + 1 : 0;
                            done <= 1'b0;
                            run <= 20;
                        end
                    end
                    8'h08: begin
                        // a word with no request pending is dropped
                        if (erdy) begin
                            words[got] <= unit_wdata;
                            got <= got + 1;
                            erdy <= 1'b0;
                            run <= 10;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule : pkcx_unit_model
